// ### sfc_pkg.sv
`default_nettype none

package sfc_pkg;

    // register addresses on the serial register port
    localparam logic [6:0] ADDR_TRIM_LO  = 7'h73;
    localparam logic [6:0] ADDR_TRIM_HI  = 7'h74;
    localparam logic [6:0] ADDR_BAND_INT = 7'h75;
    localparam logic [6:0] ADDR_FINE_HI  = 7'h76;
    localparam logic [6:0] ADDR_FINE_LO  = 7'h77;
    localparam logic [6:0] ADDR_HOP_CHAN = 7'h79;
    localparam logic [6:0] ADDR_HOP_STEP = 7'h7A;

    // power-on values
    localparam logic [7:0] RST_TRIM_LO  = 8'h00;
    localparam logic [1:0] RST_TRIM_HI  = 2'h0;
    localparam logic [6:0] RST_BAND_INT = 7'h35;
    localparam logic [7:0] RST_FINE_HI  = 8'hBB;
    localparam logic [7:0] RST_FINE_LO  = 8'h80;
    localparam logic [7:0] RST_HOP      = 8'h00;

    // field layout of the band / integer register, and the trim word width
    localparam int BIT_UPPER_BAND = 5;
    localparam int BIT_SIDE_BAND  = 6;
    localparam int INT_SEL_W      = 5;
    localparam int TRIM_W         = 10;

    // division arithmetic, word constants in fine-word steps of 156.25 Hz x (band+1)
    localparam int WORD_W = 25;
    typedef logic [WORD_W-1:0] sfc_word_t;
    localparam logic [4:0] INT_SEL_MAX = 5'h17;
    localparam logic [5:0] INT_OFFSET  = 6'h18;
    localparam sfc_word_t  FRAC_MOD    = 25'h000FA00;
    localparam sfc_word_t  IF_SHIFT_LB = 25'h0001770;
    localparam sfc_word_t  IF_SHIFT_HB = 25'h0000BB8;
    localparam int HOP_SHIFT_LB = 6;
    localparam int HOP_SHIFT_HB = 5;

    // timing
    localparam int CLK_MHZ    = 100;
    localparam int REF_MHZ    = 10;
    localparam int REF_DIV    = CLK_MHZ / REF_MHZ;
    localparam int SETTLE_US  = 100;
    localparam int TOTAL_US   = 200;
    localparam int BIAS_US    = 50;
    localparam int CAL_US     = TOTAL_US - BIAS_US - SETTLE_US;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
    localparam int BIAS_CYC   = BIAS_US * CLK_MHZ;
    localparam int CAL_CYC    = CAL_US * CLK_MHZ;
    localparam int CNT_W      = 16;

    typedef enum logic [5:0] {
        ST_OFF    = 6'h01,
        ST_BIAS   = 6'h02,
        ST_CAL    = 6'h04,
        ST_SETTLE = 6'h08,
        ST_TUNE   = 6'h10,
        ST_RX     = 6'h20
    } sfc_state_e;

    typedef struct packed {
        logic synth_en;
        logic xtal_en;
        logic vco_cal;
        logic rx_en;
        logic lo_ready;
    } sfc_ctrl_s;

endpackage

`default_nettype wire

// ### sfc_synth_freq_ctrl.sv
// Behaviour
// - oscillator recalibrates by itself on any change of the unmodulated word (not deviation) and at power-up
// - synthesizer settling interval defaults to 100 us before receive enable
// - bias settling, calibration and settling together last 200 us
// - third-order delta-sigma at 10 MHz reference, accumulators modulo 64000
// - carrier = 10 MHz x (band+1) x (integer+24+fine/64000)
// - integer select values above 23 are stored as 23
// - upper band bypasses output halving divider, lower band halves
// - fraction built from fine word, trim word and deviation word
// - data bits shift fraction up or down by the deviation word
// - receive mode lowers synthesizer by 937.5 kHz, low-side injection
// - hop step register counts in 10 kHz units, up to 2.55 MHz
// - carrier adds step x channel x 10 kHz; channel write alone retunes
// - hop write during receive returns to tune sequence, applies new frequency
// - ten-bit trim is two's complement, 156.25 Hz x (band+1) per step
// - trim covers +-160 kHz in upper band, +-80 kHz in lower band
// - trim shifts the local oscillator
// - trim low eight bits in first register, top two in second
// - host sets only target mode; sequencer performs whole transition
// - keep-on request gives tune mode with synth and crystal enabled
`timescale 1ns/1ps
`default_nettype none

module sfc_mod_acc #(
    parameter int                     W       = 16,
    parameter logic [sfc_pkg::WORD_W-1:0] MODULUS = sfc_pkg::FRAC_MOD
) (
    input  wire logic         clk_sys, // system clock
    input  wire logic         resetn,  // async reset, low
    input  wire logic         tick,    // reference tick
    input  wire logic [W-1:0] add,     // value added each tick
    output logic      [W-1:0] acc,     // residue
    output logic              carry    // overflow of last tick
);
    logic [W-1:0] acc_q;
    logic         carry_q;
    wire  [W:0]   sum  = {1'b0, acc_q} + {1'b0, add};
    wire          wrap = sum >= MODULUS[W:0];
    wire  [W:0]   nxt  = wrap ? sum - MODULUS[W:0] : sum;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            acc_q   <= '0;
            carry_q <= 1'b0;
        end else if (tick) begin
            acc_q   <= nxt[W-1:0];
            carry_q <= wrap;
        end
    end

    assign acc   = acc_q;
    assign carry = carry_q;
endmodule

module sfc_synth_freq_ctrl #(
    parameter int BIAS_CYC   = sfc_pkg::BIAS_CYC,
    parameter int CAL_CYC    = sfc_pkg::CAL_CYC,
    parameter int SETTLE_CYC = sfc_pkg::SETTLE_CYC
) (
    input  wire logic        clk_sys,        // 100 MHz system clock
    input  wire logic        resetn,         // async reset, low
    input  wire logic        shutdown,       // shutdown request, high
    input  wire logic [6:0]  reg_addr,       // register address
    input  wire logic        reg_wr,         // write strobe, one cycle
    input  wire logic [7:0]  reg_wdata,      // write data
    output logic      [7:0]  reg_rdata,      // read data for reg_addr
    input  wire logic        synth_keep_on,  // tune mode request
    input  wire logic        rx_on,          // receive mode request
    input  wire logic        mod_data,       // incoming data bit
    input  wire logic [7:0]  deviation_word, // deviation in fine steps
    output sfc_pkg::sfc_ctrl_s ctrl,         // analog enables
    output logic             upper_band,     // divide-by-two bypassed
    output logic      [6:0]  synth_int,      // integer division N
    output logic      [15:0] synth_frac,     // fraction F, below 64000
    output logic      [7:0]  dsm_div,        // modulated division this tick
    output logic      [2:0]  seq_state       // 0 off,1 bias,2 cal,3 settle,4 tune,5 rx
);
    localparam int CW = sfc_pkg::CNT_W;
    localparam int IW = sfc_pkg::INT_SEL_W;
    localparam int TW = sfc_pkg::TRIM_W;
    localparam int WW = sfc_pkg::WORD_W;

    // ---------------- registers ----------------
    logic [7:0]      trim_lo_q;
    logic [1:0]      trim_hi_q;
    logic [6:0]      band_int_q;
    logic [7:0]      fine_hi_q;
    logic [7:0]      fine_lo_q;
    logic [7:0]      hop_chan_q;
    logic [7:0]      hop_step_q;

    // no host writes while shut down, the contents are being restored anyway
    wire wr_ok       = reg_wr && !shutdown;
    wire wr_trim_lo  = wr_ok && (reg_addr == sfc_pkg::ADDR_TRIM_LO);
    wire wr_trim_hi  = wr_ok && (reg_addr == sfc_pkg::ADDR_TRIM_HI);
    wire wr_band_int = wr_ok && (reg_addr == sfc_pkg::ADDR_BAND_INT);
    wire wr_fine_hi  = wr_ok && (reg_addr == sfc_pkg::ADDR_FINE_HI);
    wire wr_fine_lo  = wr_ok && (reg_addr == sfc_pkg::ADDR_FINE_LO);
    wire wr_hop_chan = wr_ok && (reg_addr == sfc_pkg::ADDR_HOP_CHAN);
    wire wr_hop_step = wr_ok && (reg_addr == sfc_pkg::ADDR_HOP_STEP);

    wire [IW-1:0] int_sel_in = (reg_wdata[IW-1:0] > sfc_pkg::INT_SEL_MAX) ?
                               sfc_pkg::INT_SEL_MAX : reg_wdata[IW-1:0];
    wire [6:0] band_int_in = {reg_wdata[sfc_pkg::BIT_SIDE_BAND],
                              reg_wdata[sfc_pkg::BIT_UPPER_BAND], int_sel_in};

    // shutdown loses register contents, so restore defaults while it is held
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            trim_lo_q  <= sfc_pkg::RST_TRIM_LO;
            trim_hi_q  <= sfc_pkg::RST_TRIM_HI;
            band_int_q <= sfc_pkg::RST_BAND_INT;
            fine_hi_q  <= sfc_pkg::RST_FINE_HI;
            fine_lo_q  <= sfc_pkg::RST_FINE_LO;
            hop_chan_q <= sfc_pkg::RST_HOP;
            hop_step_q <= sfc_pkg::RST_HOP;
        end else if (shutdown) begin
            trim_lo_q  <= sfc_pkg::RST_TRIM_LO;
            trim_hi_q  <= sfc_pkg::RST_TRIM_HI;
            band_int_q <= sfc_pkg::RST_BAND_INT;
            fine_hi_q  <= sfc_pkg::RST_FINE_HI;
            fine_lo_q  <= sfc_pkg::RST_FINE_LO;
            hop_chan_q <= sfc_pkg::RST_HOP;
            hop_step_q <= sfc_pkg::RST_HOP;
        end else begin
            if (wr_trim_lo)  trim_lo_q  <= reg_wdata;
            if (wr_trim_hi)  trim_hi_q  <= reg_wdata[1:0];
            if (wr_band_int) band_int_q <= band_int_in;
            if (wr_fine_hi)  fine_hi_q  <= reg_wdata;
            if (wr_fine_lo)  fine_lo_q  <= reg_wdata;
            if (wr_hop_chan) hop_chan_q <= reg_wdata;
            if (wr_hop_step) hop_step_q <= reg_wdata;
        end
    end

    // reserved bits read back as zero
    wire [7:0] rd_sel =
        (reg_addr == sfc_pkg::ADDR_TRIM_LO)  ? trim_lo_q :
        (reg_addr == sfc_pkg::ADDR_TRIM_HI)  ? {6'h00, trim_hi_q} :
        (reg_addr == sfc_pkg::ADDR_BAND_INT) ? {1'b0, band_int_q} :
        (reg_addr == sfc_pkg::ADDR_FINE_HI)  ? fine_hi_q :
        (reg_addr == sfc_pkg::ADDR_FINE_LO)  ? fine_lo_q :
        (reg_addr == sfc_pkg::ADDR_HOP_CHAN) ? hop_chan_q :
        (reg_addr == sfc_pkg::ADDR_HOP_STEP) ? hop_step_q : 8'h00;

    // ---------------- frequency word ----------------
    wire          hb        = band_int_q[sfc_pkg::BIT_UPPER_BAND];
    wire [5:0]    int_n     = {1'b0, band_int_q[IW-1:0]} + sfc_pkg::INT_OFFSET;
    wire [15:0]   fine      = {fine_hi_q, fine_lo_q};
    wire [TW-1:0] trim      = {trim_hi_q, trim_lo_q};
    // trim steps equal fine steps in both bands, so it adds straight in
    wire [WW-1:0] trim_ext  = {{(WW-TW){trim[TW-1]}}, trim};
    wire [15:0]   hop_prod  = hop_step_q * hop_chan_q;
    // one 10 kHz unit is 64 fine steps low band, 32 high band
    wire [WW-1:0] hop_words = hb ? (WW'(hop_prod) << sfc_pkg::HOP_SHIFT_HB) :
                                   (WW'(hop_prod) << sfc_pkg::HOP_SHIFT_LB);
    wire [WW-1:0] if_shift  = !rx_on ? '0 :
                              (hb ? sfc_pkg::IF_SHIFT_HB : sfc_pkg::IF_SHIFT_LB);
    wire [WW-1:0] int_words = WW'(int_n) * sfc_pkg::FRAC_MOD;
    wire [WW-1:0] nom_word  = int_words + {9'h000, fine} + trim_ext + hop_words - if_shift;
    wire [WW-1:0] dev_ext   = {17'h00000, deviation_word};
    wire [WW-1:0] mod_word  = mod_data ? nom_word + dev_ext : nom_word - dev_ext;
    wire [WW-1:0] int_quot  = mod_word / sfc_pkg::FRAC_MOD;
    wire [WW-1:0] frac_rem  = mod_word % sfc_pkg::FRAC_MOD;

    // ---------------- sequencer ----------------
    sfc_pkg::sfc_state_e state_q, state_d;
    logic [CW-1:0]   cnt_q, cnt_d;
    // word the oscillator was last calibrated for
    logic [WW-1:0]   applied_q;

    wire cnt_done  = (cnt_q == '0);
    wire want_on   = (synth_keep_on || rx_on) && !shutdown;
    // deviation is left out so modulation never triggers a recalibration
    wire freq_chg  = (nom_word != applied_q);
    // a hop write in receive retunes even when it leaves the word unchanged
    wire hop_in_rx = (state_q == sfc_pkg::ST_RX) && (wr_hop_chan || wr_hop_step);
    wire restart   = (state_q != sfc_pkg::ST_OFF) && (freq_chg || hop_in_rx);

    always_comb begin
        state_d = state_q;
        case (state_q)
            sfc_pkg::ST_OFF: begin
                if (want_on) state_d = sfc_pkg::ST_BIAS;
            end
            sfc_pkg::ST_BIAS: begin
                if (cnt_done) state_d = sfc_pkg::ST_CAL;
            end
            sfc_pkg::ST_CAL: begin
                if (cnt_done) state_d = sfc_pkg::ST_SETTLE;
            end
            sfc_pkg::ST_SETTLE: begin
                if (cnt_done) state_d = rx_on ? sfc_pkg::ST_RX : sfc_pkg::ST_TUNE;
            end
            sfc_pkg::ST_TUNE: begin
                if (rx_on) state_d = sfc_pkg::ST_RX;
            end
            sfc_pkg::ST_RX: begin
                if (!rx_on) state_d = sfc_pkg::ST_TUNE;
            end
            default: state_d = sfc_pkg::ST_OFF;
        endcase
        if (restart) state_d = sfc_pkg::ST_BIAS;
        if (!want_on) state_d = sfc_pkg::ST_OFF;
    end

    wire entering = (state_d != state_q) || restart;

    // each phase loads its own length; the three add up to the start-up total
    wire [CW-1:0] phase_len =
        (state_d == sfc_pkg::ST_BIAS)   ? CW'(BIAS_CYC - 1) :
        (state_d == sfc_pkg::ST_CAL)    ? CW'(CAL_CYC - 1) :
        (state_d == sfc_pkg::ST_SETTLE) ? CW'(SETTLE_CYC - 1) : '0;

    always_comb begin
        cnt_d = cnt_q;
        if (entering) cnt_d = phase_len;
        else if (!cnt_done) cnt_d = cnt_q - 1'b1;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q   <= sfc_pkg::ST_OFF;
            cnt_q     <= '0;
            applied_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            if (state_d == sfc_pkg::ST_BIAS && entering) applied_q <= nom_word;
        end
    end

    // ---------------- delta-sigma at reference rate ----------------
    // modulator and its carries advance only on reference ticks
    logic [3:0] ref_cnt_q;
    wire        ref_tick = (ref_cnt_q == 4'(sfc_pkg::REF_DIV - 1));

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) ref_cnt_q <= '0;
        else ref_cnt_q <= ref_tick ? 4'h0 : ref_cnt_q + 4'h1;
    end

    logic [15:0] acc1, acc2;
    logic        c1, c2, c3;

    sfc_mod_acc #(.W(16)) u_acc1 (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .tick    (ref_tick),
        .add     (frac_rem[15:0]),
        .acc     (acc1),
        .carry   (c1)
    );
    sfc_mod_acc #(.W(16)) u_acc2 (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .tick    (ref_tick),
        .add     (acc1),
        .acc     (acc2),
        .carry   (c2)
    );
    sfc_mod_acc #(.W(16)) u_acc3 (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .tick    (ref_tick),
        .add     (acc2),
        .acc     (),
        .carry   (c3)
    );

    logic c2d_q, c3d_q, c3dd_q;
    // third-order noise shaping: c1 + (1-z)c2 + (1-z)^2 c3
    wire [7:0] dsm_d = {1'b0, int_quot[6:0]} + {7'h00, c1} + {7'h00, c2} - {7'h00, c2d_q}
                       + {7'h00, c3} - {6'h00, c3d_q, 1'b0} + {7'h00, c3dd_q};

    // ---------------- output flops ----------------
    logic [7:0]         rdata_q;
    sfc_pkg::sfc_ctrl_s ctrl_q, ctrl_d;
    logic               upper_band_q;
    logic [6:0]         synth_int_q;
    logic [15:0]        synth_frac_q;
    logic [7:0]         dsm_div_q;
    logic [2:0]         seq_state_q;

    always_comb begin
        ctrl_d          = '0;
        ctrl_d.synth_en = (state_d != sfc_pkg::ST_OFF);
        ctrl_d.xtal_en  = (state_d != sfc_pkg::ST_OFF);
        ctrl_d.vco_cal  = (state_d == sfc_pkg::ST_CAL);
        ctrl_d.rx_en    = (state_d == sfc_pkg::ST_RX);
        ctrl_d.lo_ready = (state_d == sfc_pkg::ST_RX) || (state_d == sfc_pkg::ST_TUNE);
    end

    wire [2:0] state_code =
        (state_d == sfc_pkg::ST_BIAS)   ? 3'h1 :
        (state_d == sfc_pkg::ST_CAL)    ? 3'h2 :
        (state_d == sfc_pkg::ST_SETTLE) ? 3'h3 :
        (state_d == sfc_pkg::ST_TUNE)   ? 3'h4 :
        (state_d == sfc_pkg::ST_RX)     ? 3'h5 : 3'h0;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_q      <= '0;
            ctrl_q       <= '0;
            upper_band_q <= 1'b0;
            synth_int_q  <= '0;
            synth_frac_q <= '0;
            dsm_div_q    <= '0;
            seq_state_q  <= '0;
            c2d_q        <= 1'b0;
            c3d_q        <= 1'b0;
            c3dd_q       <= 1'b0;
        end else begin
            rdata_q      <= rd_sel;
            ctrl_q       <= ctrl_d;
            upper_band_q <= hb;
            synth_int_q  <= int_quot[6:0];
            synth_frac_q <= frac_rem[15:0];
            seq_state_q  <= state_code;
            if (ref_tick) begin
                dsm_div_q <= dsm_d;
                c2d_q     <= c2;
                c3d_q     <= c3;
                c3dd_q    <= c3d_q;
            end
        end
    end

    assign reg_rdata  = rdata_q;
    assign ctrl       = ctrl_q;
    assign upper_band = upper_band_q;
    assign synth_int  = synth_int_q;
    assign synth_frac = synth_frac_q;
    assign dsm_div    = dsm_div_q;
    assign seq_state  = seq_state_q;
endmodule

`default_nettype wire

// ### sfc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module sfc_host_model (
    input  wire logic       clk_sys,   // bench clock
    input  wire logic [7:0] reg_rdata, // device read data
    output logic      [6:0] reg_addr,  // register address
    output logic            reg_wr,    // write strobe
    output logic      [7:0] reg_wdata  // write data
);
    initial begin
        reg_addr  = 7'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
    end

    // host names only the target value, the device sequences the rest
    // no automatic correction exists here, so trim writes are always legal
    task automatic write(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk_sys);
        reg_wr    = 1'b0;
        reg_wdata = ~d; // released data must not look held
    endtask

    task automatic read(input logic [6:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
endmodule

`default_nettype wire

// ### sfc_synth_freq_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module sfc_synth_freq_ctrl_assertions #(
    parameter int BIAS_CYC   = 4,
    parameter int CAL_CYC    = 4,
    parameter int SETTLE_CYC = 8
) (
    input wire logic               clk_sys,       // clock
    input wire logic               resetn,        // reset, low
    input wire logic               shutdown,      // shutdown
    input wire logic [6:0]         reg_addr,      // address
    input wire logic               reg_wr,        // write strobe
    input wire logic [7:0]         reg_rdata,     // read data
    input wire logic               synth_keep_on, // tune request
    input wire logic               rx_on,         // rx request
    input wire sfc_pkg::sfc_ctrl_s ctrl,          // enables
    input wire logic [15:0]        synth_frac,    // fraction
    input wire logic [2:0]         seq_state      // state code
);
    logic [2:0]  prev_q;
    logic [15:0] run_q;

    // run_q is the length of the state run that just ended in prev_q
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prev_q <= 3'h0;
            run_q  <= 16'h0000;
        end else begin
            prev_q <= seq_state;
            run_q  <= (seq_state == prev_q) ? run_q + 16'h0001 : 16'h0001;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    property p_off_to_bias;
        seq_state == 3'h0 && !shutdown && (synth_keep_on || rx_on) |=> seq_state == 3'h1;
    endproperty
    a_off_to_bias: assert property (p_off_to_bias) else $error("sequencer stayed off");
    property p_bias_len; seq_state == 3'h2 && prev_q == 3'h1 |-> run_q == BIAS_CYC; endproperty
    a_bias_len: assert property (p_bias_len) else $error("bias interval length wrong");
    property p_cal_len; seq_state == 3'h3 && prev_q == 3'h2 |-> run_q == CAL_CYC; endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
    property p_settle_len;
        seq_state inside {3'h4, 3'h5} && prev_q == 3'h3 |-> run_q == SETTLE_CYC;
    endproperty
    a_settle_len: assert property (p_settle_len) else $error("settle length wrong");
    property p_tune_ctrl;
        seq_state == 3'h4 |-> ctrl.synth_en && ctrl.xtal_en && ctrl.lo_ready && !ctrl.rx_en;
    endproperty
    a_tune_ctrl: assert property (p_tune_ctrl) else $error("tune enables wrong");
    property p_cal_flag; ctrl.vco_cal == (seq_state == 3'h2); endproperty
    a_cal_flag: assert property (p_cal_flag) else $error("calibration flag wrong");
    property p_rx_en; ctrl.rx_en == (seq_state == 3'h5); endproperty
    a_rx_en: assert property (p_rx_en) else $error("receive enable wrong");
    property p_frac_range; synth_frac < 16'hFA00; endproperty
    a_frac_range: assert property (p_frac_range) else $error("fraction not below modulus");
    property p_hop_retune;
        reg_wr && !shutdown && seq_state == 3'h5 && reg_addr inside {7'h79, 7'h7A}
            |-> ##[1:2] seq_state == 3'h1;
    endproperty
    a_hop_retune: assert property (p_hop_retune) else $error("hop write did not retune");
    property p_shutdown; shutdown |=> seq_state == 3'h0; endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown left sequencer on");
    property p_band_read;
        $past(reg_addr) == 7'h75 |-> !reg_rdata[7] && reg_rdata[4:0] <= 5'h17;
    endproperty
    a_band_read: assert property (p_band_read) else $error("band register out of range");
    property p_trim_hi_read; $past(reg_addr) == 7'h74 |-> reg_rdata[7:2] == 6'h00; endproperty
    a_trim_hi_read: assert property (p_trim_hi_read) else $error("trim high spare bits set");
endmodule

bind sfc_synth_freq_ctrl sfc_synth_freq_ctrl_assertions #(
    .BIAS_CYC(BIAS_CYC), .CAL_CYC(CAL_CYC), .SETTLE_CYC(SETTLE_CYC)) u_chk (
    .clk_sys(clk_sys), .resetn(resetn), .shutdown(shutdown), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .synth_keep_on(synth_keep_on), .rx_on(rx_on),
    .ctrl(ctrl), .synth_frac(synth_frac), .seq_state(seq_state));

`default_nettype wire

// ### sfc_synth_freq_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sfc_synth_freq_ctrl_tb;
    localparam int BIAS = 4;
    localparam int CAL  = 4;
    localparam int SETL = 8;
    localparam logic [6:0] ADDRS [7] = '{7'h73, 7'h74, 7'h75, 7'h76, 7'h77, 7'h79, 7'h7A};
    logic               clk_sys, resetn, shutdown, synth_keep_on, rx_on, mod_data, reg_wr, upper_band;
    logic [6:0]         reg_addr, synth_int;
    logic [7:0]         reg_wdata, reg_rdata, deviation_word, dsm_div, rd;
    logic [15:0]        synth_frac;
    logic [2:0]         seq_state;
    logic [7:0]         sh [7];
    sfc_pkg::sfc_ctrl_s ctrl;
    int                 err_count, checks_done, n;

    sfc_host_model u_host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
                           .reg_wr(reg_wr), .reg_wdata(reg_wdata));
    sfc_synth_freq_ctrl #(.BIAS_CYC(BIAS), .CAL_CYC(CAL), .SETTLE_CYC(SETL)) uut (
        .clk_sys(clk_sys), .resetn(resetn), .shutdown(shutdown), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .synth_keep_on(synth_keep_on), .rx_on(rx_on), .mod_data(mod_data),
        .deviation_word(deviation_word), .ctrl(ctrl), .upper_band(upper_band),
        .synth_int(synth_int), .synth_frac(synth_frac), .dsm_div(dsm_div), .seq_state(seq_state));

    function automatic logic [7:0] kept(int i, logic [7:0] d);
        if (i == 1) return d & 8'h03;
        if (i == 2) return {1'b0, d[6:5], (d[4:0] > 5'h17) ? 5'h17 : d[4:0]};
        return d;
    endfunction

    // whole division word in fine steps of 156.25 Hz x (band+1)
    function automatic longint word();
        longint w;
        w = (longint'(sh[2][4:0]) + 24) * 64000 + longint'({sh[3], sh[4]});
        w += longint'($signed({sh[1][1:0], sh[0]}));
        w += (longint'(sh[6]) * sh[5]) << (sh[2][5] ? 5 : 6);
        if (rx_on) w -= sh[2][5] ? 3000 : 6000;
        w += mod_data ? longint'(deviation_word) : -longint'(deviation_word);
        return w;
    endfunction

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wr(int i, logic [7:0] d);
        u_host.write(ADDRS[i], d);
        sh[i] = kept(i, d);
    endtask

    task automatic regs_check();
        for (int i = 0; i < 7; i++) begin
            u_host.read(ADDRS[i], rd);
            chk("register", sh[i], rd);
        end
    endtask

    task automatic word_check();
        longint w;
        // outputs lag a register write by one edge
        @(negedge clk_sys);
        w = word();
        chk("synth_int", 32'(w / 64000), synth_int);
        chk("synth_frac", 32'(w % 64000), synth_frac);
        chk("upper_band", sh[2][5], upper_band);
    endtask

    // mean of the modulator output over 200 reference ticks tracks the word;
    // carry and difference terms telescope, leaving a few counts of slack
    task automatic dsm_check();
        longint w;
        int     sum;
        w = word() * 200 / 64000;
        sum = 0;
        repeat (200) begin
            repeat (10) @(negedge clk_sys);
            sum += dsm_div;
        end
        if (sum < w - 6 || sum > w + 6) chk("dsm_div sum", 32'(w), 32'(sum));
        else checks_done++;
    endtask

    task automatic wait_state(logic [2:0] s, int lim);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (seq_state !== s && n < lim);
    endtask

    task automatic final_report();
        if (err_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // whole run is a few thousand cycles, so 200 us means a hang
    initial begin
        #200000;
        err_count++;
        final_report();
    end

    initial begin
        logic [7:0] d;
        int i;
        err_count = 0;
        checks_done = 0;
        resetn = 1'b0;
        shutdown = 1'b0;
        synth_keep_on = 1'b0;
        rx_on = 1'b0;
        mod_data = 1'b0;
        deviation_word = 8'h00;
        sh = '{8'h00, 8'h00, 8'h35, 8'hBB, 8'h80, 8'h00, 8'h00};
        void'($urandom(32'h212A));
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        resetn = 1'b1;
        regs_check();
        word_check();
        u_host.read(7'h78, rd);
        chk("unmapped", 8'h00, rd);
        for (int k = 0; k < 60; k++) begin
            i = (k < 14) ? k % 7 : $urandom_range(6);
            d = (k < 7) ? 8'hFF : ((k < 14) ? 8'h00 : 8'($urandom));
            if (i > 4) d &= 8'h1F; // keeps the hop product inside the integer range
            deviation_word = 8'($urandom);
            mod_data = 1'($urandom);
            wr(i, d);
            u_host.read(ADDRS[i], rd);
            chk("readback", sh[i], rd);
            word_check();
        end
        wr(1, 8'h01);
        wr(0, 8'hFF);
        word_check();
        dsm_check();
        synth_keep_on = 1'b1;
        wait_state(3'h4, 100);
        chk("tune time", 1 + BIAS + CAL + SETL, n);
        rx_on = 1'b1;
        wait_state(3'h5, 100);
        chk("rx state", 3'h5, seq_state);
        word_check();
        wr(5, sh[5]);
        wait_state(3'h1, 4);
        chk("hop retune", 3'h1, seq_state);
        wait_state(3'h5, 100);
        word_check();
        rx_on = 1'b0;
        wait_state(3'h4, 100);
        chk("back to tune", 3'h4, seq_state);
        shutdown = 1'b1;
        @(negedge clk_sys);
        chk("shutdown state", 3'h0, seq_state);
        shutdown = 1'b0;
        synth_keep_on = 1'b0;
        sh = '{8'h00, 8'h00, 8'h35, 8'hBB, 8'h80, 8'h00, 8'h00};
        regs_check();
        final_report();
    end
endmodule

`default_nettype wire
